/* logic/bct_baud_clock_timing.v */
`timescale 1ns/10ps
`include "bct_regs.vh"

// How it works
// R1 - 22 fixed 16x rates from comm clock
// R2 - faster comm clock scales all rates up
// R3 - all rates present, any consumer picks
// R4 - fixed outputs are sixteen times baud
// R5 - two independent 16-bit timers
// R6 - each timer picks one of eight sources
// R7 - control bit starts and stops timer
// R8 - square wave, half period from reload
// R9 - one countdown per half wave
// R10 - selected timer acts as 16x clock
// R11 - software computes reload from formula
// R12 - reload zero and one work
// R13 - consumers divide by 16, expose phases
// R14 - software rounds divide to integer
// R15 - system clock above twice comm clock
// R16 - doubled crystal doubles every rate
// R17 - comm input may stay unused
// R18 - timers reach consumers or output pin
// R19 - terminal count reloads and toggles
module bct_baud_clock_timing (
  input wire ref_clk,
  input wire rst,
  input wire comm_clock_input,
  input wire osc_enable,
  output wire crystal_drive_output,
  input wire [3:0] timer_ext_clk,
  input wire timer0_run,
  input wire [`BCT_TIMER_SRC_W-1:0] timer0_src_sel,
  input wire [7:0] timer0_reload_upper,
  input wire [7:0] timer0_reload_lower,
  input wire timer1_run,
  input wire [`BCT_TIMER_SRC_W-1:0] timer1_src_sel,
  input wire [7:0] timer1_reload_upper,
  input wire [7:0] timer1_reload_lower,
  output wire timer0_wave,
  output wire timer1_wave,
  output wire [`BCT_RATE_COUNT-1:0] fixed_rate_tick,
  input wire [`BCT_CONSUMERS*`BCT_RATE_IDX_W-1:0] consumer_sel,
  output wire [`BCT_CONSUMERS-1:0] consumer_tick,
  output wire [`BCT_CONSUMERS*`BCT_PHASE_W-1:0] consumer_phase,
  output wire [`BCT_CONSUMERS-1:0] consumer_bit_tick,
  input wire out_pin_enable,
  input wire out_pin_timer_sel,
  output wire general_output_pin
);

  function [`BCT_DIV_W-1:0] rate_div;
    input [`BCT_RATE_IDX_W-1:0] idx;
    begin
      case (idx)
        5'h00: rate_div = `BCT_DIV_50;
        5'h01: rate_div = `BCT_DIV_75;
        5'h02: rate_div = `BCT_DIV_110;
        5'h03: rate_div = `BCT_DIV_134_5;
        5'h04: rate_div = `BCT_DIV_150;
        5'h05: rate_div = `BCT_DIV_200;
        5'h06: rate_div = `BCT_DIV_300;
        5'h07: rate_div = `BCT_DIV_600;
        5'h08: rate_div = `BCT_DIV_1200;
        5'h09: rate_div = `BCT_DIV_1800;
        5'h0a: rate_div = `BCT_DIV_2000;
        5'h0b: rate_div = `BCT_DIV_2400;
        5'h0c: rate_div = `BCT_DIV_4800;
        5'h0d: rate_div = `BCT_DIV_7200;
        5'h0e: rate_div = `BCT_DIV_9600;
        5'h0f: rate_div = `BCT_DIV_14K4;
        5'h10: rate_div = `BCT_DIV_19K2;
        5'h11: rate_div = `BCT_DIV_28K8;
        5'h12: rate_div = `BCT_DIV_38K4;
        5'h13: rate_div = `BCT_DIV_57K6;
        5'h14: rate_div = `BCT_DIV_115K2;
        default: rate_div = `BCT_DIV_230K4;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; edge detect reads only the second and third stage
  reg [4:0] pin_s1_q;
  reg [4:0] pin_s2_q;
  reg [4:0] pin_s3_q;
  reg xdrv_q;

  always @(posedge ref_clk) begin
    if (rst) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      pin_s3_q <= 5'h00;
      xdrv_q <= 1'b0;
    end else begin
      pin_s1_q <= {timer_ext_clk, comm_clock_input};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      // inverting drive only while the oscillator is enabled
      xdrv_q <= osc_enable & ~pin_s2_q[0];
    end
  end

  // edges are lost if ref_clk is not above twice the pin rates
  // R15 relies on fast system clock
  wire [4:0] pin_rise = pin_s2_q & ~pin_s3_q;
  wire comm_tick = pin_rise[0];
  wire [3:0] ext_tick = pin_rise[4:1];
  assign crystal_drive_output = xdrv_q;

  ////////////////////////////////////////////////////////////////////////////
  // fixed rate divider
  reg [`BCT_RATE_COUNT-1:0] rate_tick_q;
  genvar gi;
  generate
    for (gi = 0; gi < `BCT_RATE_COUNT; gi = gi + 1) begin : g_rate
      reg [`BCT_DIV_W-1:0] cnt_q;
      localparam [31:0] rate_idx = gi;
      // R1 divide comm clock
      // R16 rates track comm clock
      // R2 faster clock scales up
      // R17 idle without comm edges
      always @(posedge ref_clk) begin
        if (rst) begin
          cnt_q <= {`BCT_DIV_W{1'b0}};
          rate_tick_q[gi] <= 1'b0;
        end else begin
          rate_tick_q[gi] <= 1'b0;
          if (comm_tick) begin
            if (cnt_q == rate_div(rate_idx[`BCT_RATE_IDX_W-1:0]) - 1'b1) begin
              cnt_q <= {`BCT_DIV_W{1'b0}};
              // R4 sixteen times baud
              rate_tick_q[gi] <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
      end
    end
  endgenerate
  // R3 all rates simultaneous
  assign fixed_rate_tick = rate_tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // programmable timers
  wire t0_tick;
  wire t1_tick;
  wire [7:0] t0_src = {ext_tick, t1_tick, rate_tick_q[`BCT_RATE_COUNT-1], 1'b1, comm_tick};
  wire [7:0] t1_src = {ext_tick, t0_tick, rate_tick_q[`BCT_RATE_COUNT-1], 1'b1, comm_tick};

  // R5 two independent timers
  bct_rate_timer u_timer0 (
    .ref_clk(ref_clk),
    .rst(rst),
    .src_tick(t0_src),
    .src_sel(timer0_src_sel),
    .run(timer0_run),
    .reload_upper(timer0_reload_upper),
    .reload_lower(timer0_reload_lower),
    .wave(timer0_wave),
    .tick16(t0_tick)
  );

  bct_rate_timer u_timer1 (
    .ref_clk(ref_clk),
    .rst(rst),
    .src_tick(t1_src),
    .src_sel(timer1_src_sel),
    .run(timer1_run),
    .reload_upper(timer1_reload_upper),
    .reload_lower(timer1_reload_lower),
    .wave(timer1_wave),
    .tick16(t1_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per consumer clock select and divide by sixteen
  generate
    for (gi = 0; gi < `BCT_CONSUMERS; gi = gi + 1) begin : g_cons
      wire [`BCT_RATE_IDX_W-1:0] sel = consumer_sel[gi*`BCT_RATE_IDX_W +: `BCT_RATE_IDX_W];
      reg pick;
      reg tick_q;
      reg bit_q;
      reg [`BCT_PHASE_W-1:0] phase_q;
      // R10 timer as 16x clock
      // R18 timers to consumers
      always @* begin
        pick = 1'b0;
        if (sel < `BCT_RATE_COUNT) begin
          pick = rate_tick_q[sel];
        end else if (sel == `BCT_SEL_TIMER0) begin
          pick = t0_tick;
        end else if (sel == `BCT_SEL_TIMER1) begin
          pick = t1_tick;
        end
      end
      // R13 divide by 16
      always @(posedge ref_clk) begin
        if (rst) begin
          tick_q <= 1'b0;
          bit_q <= 1'b0;
          phase_q <= {`BCT_PHASE_W{1'b0}};
        end else begin
          tick_q <= pick;
          bit_q <= pick & (phase_q == `BCT_PHASE_LAST);
          if (pick) begin
            phase_q <= phase_q + 1'b1;
          end
        end
      end
      assign consumer_tick[gi] = tick_q;
      assign consumer_bit_tick[gi] = bit_q;
      assign consumer_phase[gi*`BCT_PHASE_W +: `BCT_PHASE_W] = phase_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  reg out_pin_q;
  always @(posedge ref_clk) begin
    if (rst) begin
      out_pin_q <= 1'b0;
    end else begin
      // R18 timer to output pin
      out_pin_q <= out_pin_enable & (out_pin_timer_sel ? timer1_wave : timer0_wave);
    end
  end
  assign general_output_pin = out_pin_q;

endmodule

/* logic/bct_rate_timer.v */
`timescale 1ns/10ps
`include "bct_regs.vh"

module bct_rate_timer (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] src_tick,
  input wire [`BCT_TIMER_SRC_W-1:0] src_sel,
  input wire run,
  input wire [7:0] reload_upper,
  input wire [7:0] reload_lower,
  output wire wave,
  output wire tick16
);

  reg [`BCT_TIMER_W-1:0] count_q;
  reg wave_q;
  reg tick_q;
  reg run_q;
  wire [`BCT_TIMER_W-1:0] reload = {reload_upper, reload_lower};
  // reload written together with run still governs the first half period
  wire [`BCT_TIMER_W-1:0] count_now = run_q ? count_q : reload;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (rst) begin
      count_q <= {`BCT_TIMER_W{1'b0}};
      wave_q <= 1'b0;
      tick_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      run_q <= run;
      // R7 stop holds reload
      if (!run) begin
        count_q <= reload;
        wave_q <= 1'b0;
      // R6 selected source
      end else if (src_tick[src_sel]) begin
        // R19 reload and toggle
        // R12 zero and one legal: half period is reload plus one ticks
        if (count_now == {`BCT_TIMER_W{1'b0}}) begin
          count_q <= reload;
          // R9 two countdowns per period
          wave_q <= ~wave_q;
          tick_q <= ~wave_q;
        end else begin
          count_q <= count_now - 1'b1;
        end
      end else begin
        count_q <= count_now;
      end
    end
  end

  // R8 symmetrical square wave
  assign wave = wave_q;
  assign tick16 = tick_q;

endmodule

/* pkg/bct_regs.vh */
`ifndef BCT_REGS_VH
`define BCT_REGS_VH

// fixed rate table size and counter widths
`define BCT_RATE_COUNT 22
`define BCT_RATE_IDX_W 5
`define BCT_DIV_W 13
`define BCT_TIMER_W 16
`define BCT_TIMER_SRC_W 3
`define BCT_CONSUMERS 8
`define BCT_PHASE_W 4
`define BCT_PHASE_LAST 4'hf

// consumer select codes above the fixed rates
`define BCT_SEL_TIMER0 5'h16
`define BCT_SEL_TIMER1 5'h17

// timer clock source codes
`define BCT_SRC_COMM 3'h0
`define BCT_SRC_SYSCLK 3'h1
`define BCT_SRC_FIXED_FAST 3'h2
`define BCT_SRC_OTHER_TIMER 3'h3
`define BCT_SRC_EXT0 3'h4

// comm clock divisors for the 16x rates, nominal 3.6864 MHz comm clock
`define BCT_DIV_50 13'h1200
`define BCT_DIV_75 13'h0c00
`define BCT_DIV_110 13'h082f
`define BCT_DIV_134_5 13'h06b1
`define BCT_DIV_150 13'h0600
`define BCT_DIV_200 13'h0480
`define BCT_DIV_300 13'h0300
`define BCT_DIV_600 13'h0180
`define BCT_DIV_1200 13'h00c0
`define BCT_DIV_1800 13'h0080
`define BCT_DIV_2000 13'h0073
`define BCT_DIV_2400 13'h0060
`define BCT_DIV_4800 13'h0030
`define BCT_DIV_7200 13'h0020
`define BCT_DIV_9600 13'h0018
`define BCT_DIV_14K4 13'h0010
`define BCT_DIV_19K2 13'h000c
`define BCT_DIV_28K8 13'h0008
`define BCT_DIV_38K4 13'h0006
`define BCT_DIV_57K6 13'h0004
`define BCT_DIV_115K2 13'h0002
`define BCT_DIV_230K4 13'h0001

`endif

/* verification/bct_baud_clock_timing_properties.sv */
`timescale 1ns/10ps
module bct_clock_checker (
  input wire ref_clk,
  input wire rst,
  input wire timer0_run,
  input wire [2:0] timer0_src_sel,
  input wire [7:0] timer0_reload_upper,
  input wire [7:0] timer0_reload_lower,
  input wire timer0_wave,
  input wire timer1_wave,
  input wire [21:0] fixed_rate_tick,
  input wire [39:0] consumer_sel,
  input wire [7:0] consumer_tick,
  input wire [31:0] consumer_phase,
  input wire [7:0] consumer_bit_tick,
  input wire out_pin_enable,
  input wire out_pin_timer_sel,
  input wire general_output_pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire fast = timer0_run && timer0_src_sel == 3'h1 && {timer0_reload_upper, timer0_reload_lower} == 16'h0;
  stop_clears_a: assert property (!timer0_run |=> !timer0_wave)
    else $error("timer wave high while stopped");
  zero_reload_a: assert property (fast [*2] |=> timer0_wave != $past(timer0_wave))
    else $error("zero reload wave did not toggle");
  pin_route_a: assert property (!$past(rst) |-> general_output_pin ==
    $past(out_pin_enable && (out_pin_timer_sel ? timer1_wave : timer0_wave))) else $error("output pin route wrong");
  sel_route_a: assert property (!$past(rst) && $stable(consumer_sel[4:0]) && consumer_sel[4:0] == 5'h15
    |-> consumer_tick[0] == $past(fixed_rate_tick[21])) else $error("consumer tick not the selected rate");
  bit_phase_a: assert property (consumer_bit_tick[0] |-> consumer_tick[0] && consumer_phase[3:0] == 4'h0)
    else $error("bit tick off phase wrap");
  phase_step_a: assert property (consumer_tick[1] |-> consumer_phase[7:4] == $past(consumer_phase[7:4]) + 4'h1)
    else $error("phase did not step");
  rate_nest_a: assert property ((fixed_rate_tick[19] |-> fixed_rate_tick[20]) and (fixed_rate_tick[20] |-> fixed_rate_tick[21]))
    else $error("fixed rates out of step");
  tick_single_a: assert property (fixed_rate_tick[21] |=> !fixed_rate_tick[21])
    else $error("fixed tick wider than a cycle");
  cover property (consumer_bit_tick[0]);
  cover property (general_output_pin && out_pin_timer_sel);
  cover property (fast [*3]);
endmodule
bind bct_baud_clock_timing bct_clock_checker chk (.ref_clk, .rst, .timer0_run, .timer0_src_sel,
  .timer0_reload_upper, .timer0_reload_lower, .timer0_wave, .timer1_wave, .fixed_rate_tick, .consumer_sel,
  .consumer_tick, .consumer_phase, .consumer_bit_tick, .out_pin_enable, .out_pin_timer_sel, .general_output_pin);

/* verification/bct_baud_clock_timing_test.sv */
`timescale 1ns/10ps
`include "bct_regs.vh"
module bct_baud_clock_timing_test;
  logic ref_clk = 0, rst = 1, comm_clock_input = 0, timer0_run = 0, timer1_run = 0, out_pin_timer_sel = 0;
  logic out_pin_enable = 0, ext_walk = 0;
  logic [3:0] timer_ext_clk = 4'h0;
  logic [2:0] timer0_src_sel = 3'h1, timer1_src_sel = 3'h1;
  logic [7:0] timer0_reload_upper = 8'h0, timer0_reload_lower = 8'h0, timer1_reload_upper = 8'h0;
  logic [7:0] timer1_reload_lower = 8'h0;
  logic [39:0] consumer_sel = {30'h3fffffff, 5'h17, 5'h16};
  wire [21:0] fixed_rate_tick;
  wire [7:0] consumer_tick, consumer_bit_tick;
  wire [31:0] consumer_phase;
  wire timer0_wave, timer1_wave, general_output_pin, crystal_drive_output, sink_bad;
  int seed = 32'h8b81, n_errors = 0, samples_checked = 0, cyc = 0, n, r, r1;
  int dv[10] = '{48, 32, 24, 16, 12, 8, 6, 4, 2, 1};
  wire [24:0] mv = {timer1_wave, consumer_bit_tick[0], timer0_wave, fixed_rate_tick};
  logic [24:0] pm;
  always #2 ref_clk = ~ref_clk;
  // comm edges kept off the sampling edge, ten cycles a period
  // slow comm clock
  always #20 comm_clock_input = ~comm_clock_input;
  always @(posedge ref_clk) cyc++;
  // ext pins periodic while walked: bit k rises every 4 << k cycles
  always @(negedge ref_clk) begin
    pm <= mv;
    timer_ext_clk <= ext_walk ? {cyc[4], cyc[3], cyc[2], cyc[1]} : 4'($random(seed));
    out_pin_timer_sel <= $random(seed);
    out_pin_enable <= $random(seed);
  end
  bct_baud_clock_timing dut (.ref_clk, .rst, .comm_clock_input, .osc_enable(1'b1), .crystal_drive_output,
    .timer_ext_clk, .timer0_run, .timer0_src_sel, .timer0_reload_upper, .timer0_reload_lower, .timer1_run,
    .timer1_src_sel, .timer1_reload_upper, .timer1_reload_lower, .timer0_wave, .timer1_wave, .fixed_rate_tick,
    .consumer_sel, .consumer_tick, .consumer_phase, .consumer_bit_tick, .out_pin_enable, .out_pin_timer_sel,
    .general_output_pin);
  bct_uart_sink sink (.ref_clk, .rst, .tick(consumer_tick[1]), .bit_tick(consumer_bit_tick[1]), .bad(sink_bad));
  //////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task rise(input int b);
    int k;
    k = 0;
    @(negedge ref_clk);
    while (!(mv[b] && !pm[b]) && k < 50000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 50000) begin
      n_errors++;
      test_done;
    end
  endtask
  task per(input int b, output int p);
    int t;
    rise(b);
    t = cyc;
    rise(b);
    p = cyc - t;
  endtask
  // cycles between ticks of each timer source as this bench drives them
  function automatic int src_per(input int s);
    if (s == 1)
      return 1;
    else if (s == 3)
      return 2 * (r1 + 1);
    else if (s >= 4)
      return 1 << (s - 2);
    return 10;
  endfunction
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 0;
    r1 = $random(seed) & 7;
    {timer1_reload_upper, timer1_reload_lower} = 16'(r1);
    timer1_run = 1;
    for (int i = 0; i < 10; i++) begin
      per(12 + i, n);
      chk("fixed_period", n, dv[i] * 10);
    end
    chk("crystal_drive", crystal_drive_output, !comm_clock_input);
    $display("fixed rates done");
    for (int i = 0; i < 7; i++) begin
      r = (i < 2) ? i : (i == 2) ? 16'h0102 : $random(seed) & 15;
      @(negedge ref_clk);
      {timer0_reload_upper, timer0_reload_lower} = 16'(r);
      timer0_run = 1;
      per(22, n);
      chk("timer_period", n, 2 * (r + 1));
      if (r < 16) begin
        per(23, n);
        chk("bit_period", n, 32 * (r + 1));
      end
      @(negedge ref_clk);
      timer0_run = 0;
      repeat (3) @(negedge ref_clk);
      chk("stopped_wave", timer0_wave, 0);
    end
    $display("timers done");
    ext_walk = 1;
    for (int s = 0; s < 8; s++) begin
      r = $random(seed) & 3;
      @(negedge ref_clk);
      timer0_src_sel = 3'(s);
      {timer0_reload_upper, timer0_reload_lower} = 16'(r);
      timer0_run = 1;
      per(22, n);
      chk("source_period", n, 2 * (r + 1) * src_per(s));
      @(negedge ref_clk);
      timer0_run = 0;
    end
    ext_walk = 0;
    per(24, n);
    chk("timer1_period", n, 2 * (r1 + 1));
    $display("sources done");
    consumer_sel[4:0] = 5'h15;
    repeat (200) @(negedge ref_clk);
    chk("sink_bit_count", sink_bad, 0);
    $display("consumers done");
    test_done;
  end
endmodule

/* verification/bct_uart_sink.sv */
`timescale 1ns/10ps
module bct_uart_sink (
  input wire ref_clk,
  input wire rst,
  input wire tick,
  input wire bit_tick,
  output logic bad
);
  logic [4:0] n_q;
  logic seen_q;
  always @(posedge ref_clk) begin
    if (rst) begin
      n_q <= 5'h0;
      seen_q <= 1'b0;
      bad <= 1'b0;
    end else if (bit_tick) begin
      if (seen_q && n_q != 5'hf)
        bad <= 1'b1;
      n_q <= 5'h0;
      seen_q <= 1'b1;
    end else if (tick) begin
      n_q <= n_q + 5'h1;
    end
  end
endmodule
